// File: rtl/acf_pkg.sv
// Package for the converter configuration and result formatting block.
// Assumes one system clock and the core's special-function-register port.
package acf_pkg;

	// Register offsets in the special-function-register space
	localparam logic [7:0] CFG_ADDR     = 8'hbc;
	localparam logic [7:0] RES_LO_ADDR  = 8'hbd;
	localparam logic [7:0] RES_HI_ADDR  = 8'hbe;

	// Values after reset
	localparam logic [7:0] CFG_RESET    = 8'hf9;
	localparam logic [7:0] RES_LO_RESET = 8'h00;
	localparam logic [7:0] RES_HI_RESET = 8'h00;

	// Field positions in the configuration register
	localparam int DIV_MSB   = 7;
	localparam int DIV_LSB   = 3;
	localparam int LJST_BIT  = 2;
	localparam int EIGHT_BIT = 1;
	localparam int GAIN_BIT  = 0;
	localparam int DIV_W     = 5;

	// Conversion lengths in SAR clock cycles, MSB index and first trial code
	localparam logic [3:0] TEN_BIT_CYCLES   = 4'ha;
	localparam logic [3:0] EIGHT_BIT_CYCLES = 4'h8;
	localparam logic [3:0] MSB_INDEX        = 4'h9;
	localparam logic [9:0] FIRST_TRIAL      = 10'h200;

	typedef struct packed {
		logic [DIV_W-1:0] sar_clock_divider;
		logic             left_justify_select;
		logic             eight_bit_mode_enable;
		logic             input_gain_select;
	} acf_cfg_t;

	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} acf_result_t;

	typedef enum logic [1:0] {
		ACF_IDLE = 2'b00,
		ACF_CONV = 2'b01,
		ACF_DONE = 2'b10
	} acf_state_t;

endpackage

// File: rtl/acf_sar_clk_div.sv
// SAR conversion clock divider: a one-cycle tick every divisor+1 clocks.
// Assumes a synchronous clear from the sequencer at conversion start.
module acf_sar_clk_div #(
	parameter int DIV_W = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clear,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tick
);

	logic [DIV_W-1:0] count_r;

	always_ff @(posedge clk) begin
		if (reset || clear) begin
			count_r <= '0;
		end else if (count_r >= divisor) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + 1'b1;
		end
	end

	// Divisor zero gives a tick on every clock, the undivided rate
	always_ff @(posedge clk) begin
		if (reset || clear) begin
			tick <= 1'b0;
		end else begin
			tick <= (count_r >= divisor);
		end
	end

endmodule

// File: rtl/acf_top.sv
// Converter configuration, SAR sequencing and result byte formatting.
// Assumes the core's SFR port and a comparator result on the same clock.
//
// Operation
// - Divider bits 7:3, justify 2, eight-bit 1, gain 0
// - SAR clock is system clock over divider+1
// - Justify select chooses right or left alignment
// - Justify select ignored in eight-bit mode
// - Eight-bit enable picks 8 or 10 bit resolution
// - Right justified high byte: zeros, top two bits
// - Left justified high byte: eight most significant bits
// - Right justified low byte: lowest eight bits
// - Left justified low byte: two LSBs, then zeros
// - Eight-bit result goes whole into high byte
// - Eight-bit mode low byte reads zero
// - Result bytes load at completion, unused bits zero
// - Eight-bit conversion takes two fewer SAR cycles
// - Converter works only while enable is set
module acf_top (
	input  wire logic       clk,
	input  wire logic       reset,
	// Special-function-register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_r,
	// Conversion control
	input  wire logic       converter_enable,
	input  wire logic       start_conv,
	input  wire logic       cmp_ge,
	output logic      [9:0] sar_trial_r,
	output logic            sar_tick_r,
	output logic            busy_r,
	output logic            done_r,
	output logic            gain_one_r,
	output logic            powered_r
);

	acf_pkg::acf_cfg_t    cfg_r;
	acf_pkg::acf_cfg_t    shadow_r;
	acf_pkg::acf_result_t result_r;
	acf_pkg::acf_result_t result_nxt;
	acf_pkg::acf_state_t  state_r;
	acf_pkg::acf_state_t  state_nxt;

	logic [3:0]              bit_r;
	logic [3:0]              last_bit;
	logic [9:0]              code_nxt;
	logic [acf_pkg::DIV_W-1:0] divisor;
	logic                    tick;
	logic                    start_ok;
	logic                    last_tick;

	// Starts are taken only while idle and enabled
	assign start_ok  = (state_r == acf_pkg::ACF_IDLE) && start_conv
		&& converter_enable;
	// Eight-bit stops two bit positions early
	assign last_bit  = acf_pkg::MSB_INDEX + 4'h1 - (shadow_r.eight_bit_mode_enable
		? acf_pkg::EIGHT_BIT_CYCLES : acf_pkg::TEN_BIT_CYCLES);
	// Final comparison of the conversion in progress
	assign last_tick = (state_r == acf_pkg::ACF_CONV) && tick
		&& (bit_r == last_bit);
	// Conversions use the snapshot, idle uses the live setting
	assign divisor   = (state_r == acf_pkg::ACF_CONV)
		? shadow_r.sar_clock_divider : cfg_r.sar_clock_divider;

	// Restarted at each start so the first tick lands divider+1 later
	acf_sar_clk_div #(
		.DIV_W (acf_pkg::DIV_W)
	) u_div (
		.clk     (clk),
		.reset   (reset),
		.clear   (start_ok),
		.divisor (divisor),
		.tick    (tick)
	);

	// Configuration register
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_r <= acf_pkg::CFG_RESET;
		end else if (sfr_wr && sfr_addr == acf_pkg::CFG_ADDR) begin
			cfg_r <= sfr_wdata;
		end
	end

	// Settings are frozen for the duration of a conversion
	always_ff @(posedge clk) begin
		if (reset) begin
			shadow_r <= acf_pkg::CFG_RESET;
		end else if (start_ok) begin
			shadow_r <= cfg_r;
		end
	end

	// Sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			acf_pkg::ACF_IDLE: begin
				if (start_ok) begin
					state_nxt = acf_pkg::ACF_CONV;
				end
			end
			acf_pkg::ACF_CONV: begin
				// Dropping the enable abandons the conversion
				if (!converter_enable) begin
					state_nxt = acf_pkg::ACF_IDLE;
				end else if (last_tick) begin
					state_nxt = acf_pkg::ACF_DONE;
				end
			end
			acf_pkg::ACF_DONE: begin
				state_nxt = acf_pkg::ACF_IDLE;
			end
			default: begin
				state_nxt = acf_pkg::ACF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= acf_pkg::ACF_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Successive approximation: keep or drop the trial bit, then try the next
	always_comb begin
		code_nxt = sar_trial_r;
		if (!cmp_ge) begin
			code_nxt[bit_r] = 1'b0;
		end
		if (bit_r != last_bit) begin
			code_nxt[bit_r - 4'h1] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sar_trial_r <= 10'h000;
			bit_r       <= acf_pkg::MSB_INDEX;
		end else if (start_ok) begin
			sar_trial_r <= acf_pkg::FIRST_TRIAL;
			bit_r       <= acf_pkg::MSB_INDEX;
		end else if (state_r == acf_pkg::ACF_CONV && tick) begin
			sar_trial_r <= code_nxt;
			if (bit_r != last_bit) begin
				bit_r <= bit_r - 4'h1;
			end
		end
	end

	// Result formatting from the final code
	always_comb begin
		if (shadow_r.eight_bit_mode_enable) begin
			result_nxt.high_byte = code_nxt[9:2];
			result_nxt.low_byte  = 8'h00;
		end else if (shadow_r.left_justify_select) begin
			result_nxt.high_byte = code_nxt[9:2];
			result_nxt.low_byte  = {code_nxt[1:0], 6'h00};
		end else begin
			result_nxt.high_byte = {6'h00, code_nxt[9:8]};
			result_nxt.low_byte  = code_nxt[7:0];
		end
	end

	// Completion load wins over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			result_r <= {acf_pkg::RES_HI_RESET, acf_pkg::RES_LO_RESET};
		end else if (last_tick && converter_enable) begin
			result_r <= result_nxt;
		end else if (sfr_wr && sfr_addr == acf_pkg::RES_HI_ADDR) begin
			result_r.high_byte <= sfr_wdata;
		end else if (sfr_wr && sfr_addr == acf_pkg::RES_LO_ADDR) begin
			result_r.low_byte <= sfr_wdata;
		end
	end

	// Register read, unmapped addresses answer zero
	// Result bytes read back as stored, software writes included
	always_ff @(posedge clk) begin
		if (reset) begin
			sfr_rdata_r <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == acf_pkg::CFG_ADDR) begin
				sfr_rdata_r <= cfg_r;
			end else if (sfr_addr == acf_pkg::RES_LO_ADDR) begin
				sfr_rdata_r <= result_r.low_byte;
			end else if (sfr_addr == acf_pkg::RES_HI_ADDR) begin
				sfr_rdata_r <= result_r.high_byte;
			end else begin
				sfr_rdata_r <= 8'h00;
			end
		end
	end

	// Status and analog control outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			sar_tick_r <= 1'b0;
			powered_r  <= 1'b0;
			gain_one_r <= acf_pkg::CFG_RESET[acf_pkg::GAIN_BIT];
		end else begin
			busy_r     <= (state_nxt == acf_pkg::ACF_CONV);
			done_r     <= last_tick && converter_enable;
			sar_tick_r <= tick && (state_r == acf_pkg::ACF_CONV);
			powered_r  <= converter_enable;
			// Gain is set at the start edge, ahead of the first comparison
			gain_one_r <= start_ok ? cfg_r.input_gain_select
				: shadow_r.input_gain_select;
		end
	end

endmodule

// File: verification/acf_top_sva.sv
// Checker for acf_top: config shadow, conversion timing, port relations.
// Sees only the top module's ports; bound below.
module acf_top_chk (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_r,
	input wire logic       converter_enable,
	input wire logic       start_conv,
	input wire logic [9:0] sar_trial_r,
	input wire logic       sar_tick_r,
	input wire logic       busy_r,
	input wire logic       done_r,
	input wire logic       gain_one_r,
	input wire logic       powered_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [7:0] cfg_r;
	logic [7:0] snap_r;
	logic [9:0] cnt_r;
	logic [3:0] tk_r;
	logic       take;
	assign take = start_conv && converter_enable && !busy_r && !done_r;
	// Shadow of the config register, snapshot and cycle count per start
	always_ff @(posedge clk) begin
		if (reset)
			cfg_r <= acf_pkg::CFG_RESET;
		else if (sfr_wr && sfr_addr == acf_pkg::CFG_ADDR)
			cfg_r <= sfr_wdata;
	end
	always_ff @(posedge clk) begin
		if (take)
			snap_r <= cfg_r;
	end
	always_ff @(posedge clk) begin
		if (take)
			cnt_r <= 10'h000;
		else if (busy_r)
			cnt_r <= cnt_r + 10'h001;
	end
	// SAR clock pulses seen since the last start
	always_ff @(posedge clk) begin
		if (take)
			tk_r <= 4'h0;
		else if (sar_tick_r)
			tk_r <= tk_r + 4'h1;
	end
	power_follow_a: assert property (
		!$past(reset) |-> powered_r == $past(converter_enable))
		else $error("powered wrong");
	off_idle_a: assert property (
		!converter_enable && !powered_r && !$past(powered_r)
		|-> !busy_r && !done_r) else $error("active while off");
	take_busy_a: assert property (take |=> busy_r)
		else $error("start not taken");
	gain_take_a: assert property (
		take |=> gain_one_r == $past(cfg_r[0]))
		else $error("gain wrong");
	tick_count_a: assert property (
		done_r |-> sar_tick_r && tk_r == (snap_r[1] ? 4'h7 : 4'h9))
		else $error("tick count wrong");
	trial_start_a: assert property (take |=> sar_trial_r == 10'h200)
		else $error("first trial wrong");
	tick_in_conv_a: assert property (
		sar_tick_r |-> busy_r || done_r || !powered_r)
		else $error("tick outside conversion");
	conv_len_a: assert property (done_r |-> cnt_r ==
		(snap_r[1] ? 10'h008 : 10'h00a) * ({5'h00, snap_r[7:3]} + 10'h001)
		+ 10'h001) else $error("conversion length wrong");
	done_pulse_a: assert property (done_r |-> !busy_r ##1 !done_r)
		else $error("done not a pulse");
	cfg_read_a: assert property (
		sfr_rd && !sfr_wr && sfr_addr == acf_pkg::CFG_ADDR
		|=> sfr_rdata_r == cfg_r) else $error("config read wrong");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
		else $error("read data moved");
endmodule
bind acf_top acf_top_chk acf_top_chk_inst (.clk, .reset, .sfr_addr,
	.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_r, .converter_enable,
	.start_conv, .sar_trial_r, .sar_tick_r, .busy_r, .done_r,
	.gain_one_r, .powered_r);

// File: verification/acf_top_tb_top.sv
// Bench for acf_top: reset reads, table of formats, then late-config and refusal cases.
// Comparator is modelled from a target code; inputs move at negedge.
module acf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0]  c;
		logic [9:0]  t;
		logic [15:0] r;
	} acf_row_t;
	logic       clk = 1'h0, reset = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0;
	logic       converter_enable = 1'h1, start_conv = 1'h0, cmp_ge = 1'h0;
	logic       sar_tick_r, busy_r, done_r, gain_one_r, powered_r;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_r, v, h;
	logic [9:0] sar_trial_r, target = 10'h000;
	int         n_errors = 0, check_count = 0, i;
	acf_row_t   rows[6] = '{
		'{8'h00, 10'h3ff, 16'h03ff},
		'{8'h05, 10'h3ff, 16'hffc0},
		'{8'h09, 10'h201, 16'h0201},
		'{8'h14, 10'h201, 16'h8040},
		'{8'h02, 10'h2c6, 16'hb100},
		'{8'hfe, 10'h3ff, 16'hff00}
	};
	acf_top acf_top_inst (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata_r, .converter_enable, .start_conv, .cmp_ge,
		.sar_trial_r, .sar_tick_r, .busy_r, .done_r, .gain_one_r, .powered_r);
	always #4 clk = ~clk;
	always @(negedge clk) cmp_ge <= target >= sar_trial_r;
	task automatic chk(input string n, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One register access; read data lands in v
	task automatic sfr(input logic w, input logic [7:0] a, d);
		@(negedge clk);
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
		@(negedge clk);
		{sfr_wr, sfr_rd} = 2'h0;
		v = sfr_rdata_r;
	endtask
	task automatic go;
		@(negedge clk);
		start_conv = 1'h1;
		@(negedge clk);
		start_conv = 1'h0;
	endtask
	task automatic wait_done;
		for (i = 0; i < 400 && done_r !== 1'h1; i++)
			@(negedge clk);
		if (i == 400) begin
			n_errors++;
			complete_run();
		end
	endtask
	task automatic read_res;
		sfr(1'h0, 8'hbe, 8'h00);
		h = v;
		sfr(1'h0, 8'hbd, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'h0;
		sfr(1'h0, 8'hbc, 8'h00);
		h = v;
		sfr(1'h0, 8'hbd, 8'h00);
		chk("reset cfg lo", {h, v}, 16'hf900);
		sfr(1'h0, 8'hbe, 8'h00);
		h = v;
		sfr(1'h0, 8'hbf, 8'h00);
		chk("reset hi unmapped", {h, v}, 16'h0000);
		foreach (rows[k]) begin
			target = rows[k].t;
			sfr(1'h1, 8'hbc, rows[k].c);
			go();
			wait_done();
			read_res();
			chk("result", {h, v}, rows[k].r);
			chk("gain", {15'h0, gain_one_r}, {15'h0, rows[k].c[0]});
		end
		// Format change mid conversion must not touch this result
		target = 10'h155;
		sfr(1'h1, 8'hbc, 8'h18);
		go();
		sfr(1'h1, 8'hbc, 8'h06);
		wait_done();
		read_res();
		chk("late cfg", {h, v}, 16'h0155);
		// Aborted conversion leaves the written byte alone
		sfr(1'h1, 8'hbe, 8'h5a);
		sfr(1'h1, 8'hbc, 8'hf8);
		go();
		repeat (20) @(negedge clk);
		converter_enable = 1'h0;
		repeat (340) @(negedge clk);
		go();
		chk("off", {busy_r, done_r, powered_r, 13'h0}, 16'h0);
		read_res();
		chk("abort", {h, v}, 16'h5a55);
		complete_run();
	end
endmodule
